// ===== hw/tmw_input_word.sv
// multiplexed four-channel temperature input word with axi4-lite registers
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////////////////////
// Function
// - lowest sixteen image bits carry reported channel value, plain binary weights
// - two-bit channel code 00..11 names channel 1..4
// - open-input bit set while channel sensor is open, clear otherwise
// - open bits need be valid only in multiplexed reading
// - temperature reported directly in tenths of a degree
// - two's complement format offered besides magnitude plus sign
// - image holds sixteen data bits, two channel bits, four diagnostic bits
// - device appears as a 32-point discrete input unit
// - all four channels converted within each 1.4 second sampling cycle
// - voltage mode reports a 16-bit unsigned count 0 to 65535
// - temperature in fahrenheit or celsius by configuration
module tmw_input_word #(
   parameter longint SLOT_CYCLES_P = tmw_pkg::SLOT_CYCLES
) (
   input  wire logic               core_clk_in,
   input  wire logic               rst_n_in,
   input  wire logic [7:0]         s_axi_awaddr_in,
   input  wire logic               s_axi_awvalid_in,
   output      logic               s_axi_awready_out,
   input  wire logic [31:0]        s_axi_wdata_in,
   input  wire logic [3:0]         s_axi_wstrb_in,
   input  wire logic               s_axi_wvalid_in,
   output      logic               s_axi_wready_out,
   output      logic [1:0]         s_axi_bresp_out,
   output      logic               s_axi_bvalid_out,
   input  wire logic               s_axi_bready_in,
   input  wire logic [7:0]         s_axi_araddr_in,
   input  wire logic               s_axi_arvalid_in,
   output      logic               s_axi_arready_out,
   output      logic [31:0]        s_axi_rdata_out,
   output      logic [1:0]         s_axi_rresp_out,
   output      logic               s_axi_rvalid_out,
   input  wire logic               s_axi_rready_in,
   output      logic               conv_start_out,
   output      logic [1:0]         conv_chan_out,
   input  wire logic               conv_done_in,
   input  wire tmw_pkg::tmw_conv_t conv_res_in,
   input  wire logic [3:0]         open_pin_in,
   output      tmw_pkg::tmw_image_t image_out,
   output      logic               irq_out
);
   import tmw_pkg::*;

   // a single-cycle slot never reaches the channel step, so two is the least
   if (SLOT_CYCLES_P < 2 || SLOT_CYCLES_P > 64'hffff_ffff) begin : g_bad_slot
      $error("slot cycle count out of range");
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // formatting
   function automatic logic [15:0] tmw_format(input logic [15:0] raw,
                                              input logic [CTRL_W-1:0] ctrl);
      logic signed [31:0] t;
      logic [15:0]        r;
      t = 32'(signed'(raw));
      r = raw;
      if (!ctrl[CTRL_VOLT]) begin
         if (ctrl[CTRL_FAHR]) begin
            t = (t * F_MUL) / F_DIV + F_OFFSET;
         end
         if (t > SM_MAX) begin
            t = SM_MAX;
         end
         if (ctrl[CTRL_TWOS]) begin
            if (t < TC_MIN) begin
               t = TC_MIN;
            end
            r = t[15:0];
         end else begin
            if (t < -SM_MAX) begin
               t = -SM_MAX;
            end
            if (t < 0) begin
               r = SIGN_BIT | 16'((-t) & SM_MAX);
            end else begin
               r = t[15:0];
            end
         end
      end
      return r;
   endfunction : tmw_format

   function automatic logic [31:0] tmw_wmask(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
      logic [31:0] v;
      v = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            v[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return v;
   endfunction : tmw_wmask

   //////////////////////////////////////////////////////////////////////////////////////////
   // declarations
   logic [CTRL_W-1:0] ctrl_reg;
   logic [IRQ_W-1:0]  irq_stat_reg;
   logic [IRQ_W-1:0]  irq_mask_reg;
   logic [IRQ_W-1:0]  irq_set;
   logic [IRQ_W-1:0]  irq_clr;
   logic [3:0]        open_meta_reg;
   logic [3:0]        open_sync_reg;
   logic [3:0]        open_prev_reg;
   logic [15:0]       data_reg [NUM_CH];
   logic [1:0]        cur_chan_reg;
   logic [3:0]        done_seen_reg;
   logic [3:0]        done_seen_next;
   logic [31:0]       slot_cnt_reg;
   logic [1:0]        sched_chan_reg;
   logic              start_reg;
   logic              aw_hold_reg;
   logic              w_hold_reg;
   logic [7:0]        awaddr_reg;
   logic [31:0]       wdata_reg;
   logic [3:0]        wstrb_reg;
   logic              bvalid_reg;
   logic [1:0]        bresp_reg;
   logic              rvalid_reg;
   logic [31:0]       rdata_reg;
   logic [1:0]        rresp_reg;
   logic              do_write;
   logic              ar_take;
   tmw_image_t        image_reg;

   //////////////////////////////////////////////////////////////////////////////////////////
   // open-input pin synchroniser
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         open_meta_reg <= 4'h0;
         open_sync_reg <= 4'h0;
         open_prev_reg <= 4'h0;
      end else begin
         open_meta_reg <= open_pin_in;
         open_sync_reg <= open_meta_reg;
         open_prev_reg <= open_sync_reg;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // conversion scheduler, one slot per channel
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         slot_cnt_reg   <= 32'h0000_0000;
         sched_chan_reg <= 2'b00;
         start_reg      <= 1'b0;
      end else begin
         start_reg <= 1'b0;
         if (!ctrl_reg[CTRL_ENABLE]) begin
            slot_cnt_reg   <= 32'h0000_0000;
            sched_chan_reg <= 2'b00;
         end else if (slot_cnt_reg == 32'h0000_0000) begin
            start_reg    <= 1'b1;
            slot_cnt_reg <= 32'(SLOT_CYCLES_P - 1);
         end else begin
            slot_cnt_reg <= slot_cnt_reg - 32'h0000_0001;
            if (slot_cnt_reg == 32'h0000_0001) begin
               sched_chan_reg <= sched_chan_reg + 2'b01;
            end
         end
      end
   end

   assign conv_start_out = start_reg;
   assign conv_chan_out  = sched_chan_reg;

   //////////////////////////////////////////////////////////////////////////////////////////
   // per-channel results and reported channel
   always_comb begin
      done_seen_next = done_seen_reg;
      if (conv_done_in) begin
         done_seen_next[conv_res_in.chan] = 1'b1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < NUM_CH; i++) begin
            data_reg[i] <= 16'h0000;
         end
         cur_chan_reg  <= 2'b00;
         done_seen_reg <= 4'h0;
      end else if (conv_done_in) begin
         data_reg[conv_res_in.chan] <= tmw_format(conv_res_in.value, ctrl_reg);
         cur_chan_reg               <= conv_res_in.chan;
         done_seen_reg              <= (done_seen_next == 4'hf) ? 4'h0 : done_seen_next;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // input image, whole word loaded in one cycle
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         image_reg <= IMAGE_RST;
      end else begin
         image_reg.zero      <= 10'h000;
         image_reg.open_bits <= open_sync_reg;
         image_reg.chan      <= cur_chan_reg;
         image_reg.data      <= data_reg[cur_chan_reg];
      end
   end

   assign image_out = image_reg;

   //////////////////////////////////////////////////////////////////////////////////////////
   // interrupts
   always_comb begin
      irq_set            = '0;
      irq_set[IRQ_CONV]  = conv_done_in;
      irq_set[IRQ_OPEN]  = |(open_sync_reg & ~open_prev_reg);
      irq_set[IRQ_CYCLE] = conv_done_in && (done_seen_next == 4'hf);
      irq_clr            = '0;
      if (do_write && awaddr_reg == OFS_IRQ_STAT && wstrb_reg[0]) begin
         irq_clr = wdata_reg[IRQ_W-1:0];
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         irq_stat_reg <= IRQ_RST;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      end
   end

   assign irq_out = |(irq_stat_reg & irq_mask_reg);

   //////////////////////////////////////////////////////////////////////////////////////////
   // axi4-lite write channel
   assign s_axi_awready_out = !aw_hold_reg && !bvalid_reg;
   assign s_axi_wready_out  = !w_hold_reg && !bvalid_reg;
   assign do_write          = aw_hold_reg && w_hold_reg && !bvalid_reg;

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg  <= 1'b0;
         awaddr_reg  <= 8'h00;
         wdata_reg   <= 32'h0000_0000;
         wstrb_reg   <= 4'h0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_hold_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata_in;
            wstrb_reg  <= s_axi_wstrb_in;
         end
         if (do_write) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= (awaddr_reg == OFS_CTRL || awaddr_reg == OFS_IRQ_STAT ||
                            awaddr_reg == OFS_IRQ_MASK) ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_reg && s_axi_bready_in) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   assign s_axi_bvalid_out = bvalid_reg;
   assign s_axi_bresp_out  = bresp_reg;

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         ctrl_reg     <= CTRL_RST;
         irq_mask_reg <= IRQ_RST;
      end else if (do_write) begin
         if (awaddr_reg == OFS_CTRL) begin
            ctrl_reg <= CTRL_W'(tmw_wmask(32'(ctrl_reg), wdata_reg, wstrb_reg));
         end
         if (awaddr_reg == OFS_IRQ_MASK) begin
            irq_mask_reg <= IRQ_W'(tmw_wmask(32'(irq_mask_reg), wdata_reg, wstrb_reg));
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // axi4-lite read channel
   assign s_axi_arready_out = !rvalid_reg;
   assign ar_take           = s_axi_arvalid_in && !rvalid_reg;

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= RESP_OKAY;
      end else if (ar_take) begin
         rvalid_reg <= 1'b1;
         rresp_reg  <= RESP_OKAY;
         rdata_reg  <= 32'h0000_0000;
         case (s_axi_araddr_in)
            OFS_CTRL: begin
               rdata_reg <= 32'(ctrl_reg);
            end
            OFS_STATUS: begin
               rdata_reg <= {24'h00_0000, done_seen_reg, open_sync_reg};
            end
            OFS_IRQ_STAT: begin
               rdata_reg <= 32'(irq_stat_reg);
            end
            OFS_IRQ_MASK: begin
               rdata_reg <= 32'(irq_mask_reg);
            end
            OFS_IMAGE: begin
               rdata_reg <= image_reg;
            end
            OFS_CH_DATA, OFS_CH_DATA + 8'h04, OFS_CH_DATA + 8'h08, OFS_CH_DATA + 8'h0c: begin
               rdata_reg <= {16'h0000, data_reg[2'((s_axi_araddr_in - OFS_CH_DATA) >> 2)]};
            end
            default: begin
               rresp_reg <= RESP_SLVERR;
            end
         endcase
      end else if (rvalid_reg && s_axi_rready_in) begin
         rvalid_reg <= 1'b0;
      end
   end

   assign s_axi_rvalid_out = rvalid_reg;
   assign s_axi_rdata_out  = rdata_reg;
   assign s_axi_rresp_out  = rresp_reg;
endmodule : tmw_input_word

// ===== include/tmw_pkg.sv
// package for the multiplexed temperature input word block
package tmw_pkg;
   localparam int          NUM_CH          = 4;
   localparam int          CLK_MHZ         = 250;
   localparam int          SAMPLE_MS       = 1400;
   localparam longint      SAMPLE_CYCLES   = longint'(SAMPLE_MS) * longint'(CLK_MHZ) * 64'd1000;
   localparam longint      SLOT_CYCLES     = SAMPLE_CYCLES / longint'(NUM_CH);
   localparam int          F_MUL           = 9;
   localparam int          F_DIV           = 5;
   localparam int          F_OFFSET        = 320;
   localparam int          SM_MAX          = 32767;
   localparam int          TC_MIN          = -32768;
   localparam logic [15:0] SIGN_BIT        = 16'h8000;

   // register byte offsets
   localparam logic [7:0]  OFS_CTRL        = 8'h00;
   localparam logic [7:0]  OFS_STATUS      = 8'h04;
   localparam logic [7:0]  OFS_IRQ_STAT    = 8'h08;
   localparam logic [7:0]  OFS_IRQ_MASK    = 8'h0c;
   localparam logic [7:0]  OFS_IMAGE       = 8'h10;
   localparam logic [7:0]  OFS_CH_DATA     = 8'h14;

   // control bit positions
   localparam int          CTRL_ENABLE     = 0;
   localparam int          CTRL_FAHR       = 1;
   localparam int          CTRL_TWOS       = 2;
   localparam int          CTRL_VOLT       = 3;
   localparam int          CTRL_W          = 4;
   localparam logic [3:0]  CTRL_RST        = 4'h1;

   // interrupt bit positions
   localparam int          IRQ_CONV        = 0;
   localparam int          IRQ_OPEN        = 1;
   localparam int          IRQ_CYCLE       = 2;
   localparam int          IRQ_W           = 3;
   localparam logic [2:0]  IRQ_RST         = 3'h0;

   localparam logic [1:0]  RESP_OKAY       = 2'b00;
   localparam logic [1:0]  RESP_SLVERR     = 2'b10;

   // conversion result from the converter
   typedef struct packed {
      logic [1:0]  chan;
      logic [15:0] value;
   } tmw_conv_t;

   // 32-point discrete input image
   typedef struct packed {
      logic [9:0]  zero;
      logic [3:0]  open_bits;
      logic [1:0]  chan;
      logic [15:0] data;
   } tmw_image_t;

   localparam tmw_image_t IMAGE_RST = '{zero: 10'h000, open_bits: 4'h0, chan: 2'b00,
                                        data: 16'h0000};
endpackage : tmw_pkg

// ===== testbench/tmw_input_word_checker.sv
// assertion checker for the temperature input word block
`timescale 1ns/1ps
module tmw_input_word_checker
   import tmw_pkg::*;
#(
   parameter longint SLOT_P = 20
) (
   input wire logic       core_clk_in,
   input wire logic       rst_n_in,
   input wire logic       s_axi_arvalid_in,
   input wire logic       s_axi_arready_out,
   input wire logic       s_axi_rvalid_out,
   input wire logic       conv_start_out,
   input wire logic [1:0] conv_chan_out,
   input wire logic       conv_done_in,
   input wire tmw_conv_t  conv_res_in,
   input wire logic [3:0] open_pin_in,
   input wire tmw_image_t image_out
);
   int         gap;
   logic       seen;
   logic [1:0] last_ch;
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   //////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         gap <= 0;
         seen <= 1'b0;
         last_ch <= 2'b00;
      end else if (conv_start_out) begin
         gap <= 0;
         seen <= 1'b1;
         last_ch <= conv_chan_out;
      end else begin
         gap <= gap + 1;
      end
   end
   sequence s_pins_steady;
      $stable(open_pin_in) [*4];
   endsequence
   //////////////////////////////////////////////////////////////////////////////
   a_zero_pad: assert property (image_out.zero == 10'h000)
      else $error("upper image points not zero");
   a_chan_load: assert property (conv_done_in |=> ##1 image_out.chan == $past(conv_res_in.chan, 2))
      else $error("channel code not loaded with result");
   a_data_cause: assert property ($changed(image_out.data) |-> $past(conv_done_in, 2))
      else $error("image data changed without conversion");
   a_open_follow: assert property (s_pins_steady |-> image_out.open_bits == open_pin_in)
      else $error("open bits do not follow pins");
   a_start_pulse: assert property (conv_start_out |=> !conv_start_out)
      else $error("start pulse longer than one cycle");
   a_slot_gap: assert property (conv_start_out && seen |-> gap == SLOT_P - 1)
      else $error("conversion start spacing wrong");
   a_chan_cycle: assert property (conv_start_out && seen |-> conv_chan_out == last_ch + 2'd1)
      else $error("channel schedule out of order");
   a_read_lat: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
      else $error("read answer late");
   a_read_once: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
      else $error("read accepted while answer pending");
endmodule : tmw_input_word_checker
bind tmw_input_word tmw_input_word_checker #(.SLOT_P(SLOT_CYCLES_P)) i_chk (.core_clk_in,
   .rst_n_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out, .conv_start_out,
   .conv_chan_out, .conv_done_in, .conv_res_in, .open_pin_in, .image_out);

// ===== testbench/tmw_conv_model.sv
// converter model answering conversion start pulses
`timescale 1ns/1ps
module tmw_conv_model
   import tmw_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        start_in,
   input  wire logic [1:0]  chan_in,
   input  wire logic [15:0] value_in,
   input  wire logic        slow_in,
   output      logic        done_out = 1'b0,
   output      tmw_conv_t   res_out = '0
);
   int         wait_cnt = 0;
   logic [1:0] chan_reg = 2'b00;
   always @(posedge clk_in) begin
      done_out <= 1'b0;
      res_out <= ~res_out;
      if (!rst_n_in) begin
         wait_cnt <= 0;
      end else if (start_in) begin
         wait_cnt <= slow_in ? 7 : 1;
         chan_reg <= chan_in;
      end else if (wait_cnt == 1) begin
         done_out <= 1'b1;
         res_out <= '{chan: chan_reg, value: value_in};
         wait_cnt <= 0;
      end else if (wait_cnt > 1) begin
         wait_cnt <= wait_cnt - 1;
      end
   end
endmodule : tmw_conv_model

// ===== testbench/tmw_input_word_tb_top.sv
// self-checking bench for the temperature input word block
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin error_cnt++; \
   $display("wrong value %s expected %h seen %h", n, e, s); end end
module tmw_input_word_tb_top;
   import tmw_pkg::*;
   logic        core_clk_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, slow = 0;
   logic        awready, wready, bvalid, arready, rvalid, start, done, irq;
   logic [1:0]  bresp, rresp, cchan;
   logic [3:0]  open_pins = 4'h0, wstrb = 4'hf;
   logic [15:0] cval = 16'h0;
   tmw_conv_t   res;
   tmw_image_t  image;
   int          error_cnt = 0, checked = 0, n_done = 0;
   logic [31:0] seed = 32'h8ce1;
   logic [3:0]  modes [5] = '{4'h1, 4'h3, 4'h5, 4'h7, 4'h9};
   logic [15:0] corner [5] = '{16'hfffe, 16'h0000, 16'h7fff, 16'h8000, 16'hffff};
   always #2 core_clk_in = ~core_clk_in;
   always @(posedge core_clk_in) if (done) n_done <= n_done + 1;
   tmw_input_word #(.SLOT_CYCLES_P(20)) i_dut (.core_clk_in, .rst_n_in,
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
      .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
      .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .conv_start_out(start),
      .conv_chan_out(cchan), .conv_done_in(done), .conv_res_in(res),
      .open_pin_in(open_pins), .image_out(image), .irq_out(irq));
   tmw_conv_model i_conv (.clk_in(core_clk_in), .rst_n_in, .start_in(start),
      .chan_in(cchan), .value_in(cval), .slow_in(slow), .done_out(done), .res_out(res));
   //////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic logic [15:0] fmt(input logic [15:0] v, input logic [3:0] c);
      int t;
      t = c[CTRL_FAHR] ? int'($signed(v)) * F_MUL / F_DIV + F_OFFSET : int'($signed(v));
      if (c[CTRL_VOLT]) return v;
      if (c[CTRL_TWOS]) return (t < TC_MIN) ? 16'h8000 : (t > SM_MAX) ? 16'h7fff : t[15:0];
      if (t > SM_MAX) t = SM_MAX;
      if (t < -SM_MAX) t = -SM_MAX;
      return (t < 0) ? (SIGN_BIT | 16'(-t)) : t[15:0];
   endfunction : fmt
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic a_ok, w_ok;
      a_ok = 0;
      w_ok = 0;
      @(posedge core_clk_in);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(a_ok && w_ok)) begin
         @(posedge core_clk_in);
         if (!a_ok && awready) begin a_ok = 1; awvalid <= 1'b0; end
         if (!w_ok && wready) begin w_ok = 1; wvalid <= 1'b0; end
      end
      do @(posedge core_clk_in); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge core_clk_in);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge core_clk_in); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge core_clk_in); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd
   task automatic wait_done();
      do @(posedge core_clk_in); while (done !== 1'b1);
   endtask : wait_done
   task automatic test_done();
      $display("checked %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : test_done
   //////////////////////////////////////////////////////////////////////////////
   initial begin : watchdog
      #100000;
      error_cnt++;
      test_done();
   end
   initial begin : main
      logic [31:0] d;
      logic [1:0]  r, ch;
      logic [15:0] e, x;
      repeat (10) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      rd(OFS_CTRL, d, r);
      `CHK("ctrl reset", {28'h0, CTRL_RST}, d)
      rd(OFS_IRQ_MASK, d, r);
      `CHK("mask reset", 32'h0, d)
      rd(8'h24, d, r);
      `CHK("unmapped read", RESP_SLVERR, r)
      `CHK("unmapped data", 32'h0, d)
      wr(OFS_IMAGE, 32'hffff_ffff, r);
      `CHK("read-only write", RESP_SLVERR, r)
      for (int i = 0; i < 15; i++) begin
         wr(OFS_CTRL, {28'h0, modes[i % 5]}, r);
         wait_done();
         d = xs();
         x = d[15:0];
         open_pins <= x[15:12];
         slow <= x[0];
         cval <= (i < 5) ? corner[i] : {{4{x[11]}}, x[11:0]};
         wait_done();
         @(posedge core_clk_in);
         #1;
         ch = 2'(n_done - 1);
         e = fmt(cval, modes[i % 5]);
         `CHK("data", e, image.data)
         `CHK("chan code", ch, image.chan)
         `CHK("open bits", open_pins, image.open_bits)
         rd(OFS_CH_DATA + 8'(4 * ch), d, r);
         `CHK("chan reg", e, d[15:0])
         rd(OFS_IMAGE, d, r);
         `CHK("image reg", {10'h0, open_pins, ch, e}, d)
         rd(OFS_STATUS, d, r);
         `CHK("status open", open_pins, d[3:0])
      end
      wait_done();
      wstrb <= 4'he;
      wr(OFS_IRQ_STAT, 32'h7, r);
      rd(OFS_IRQ_STAT, d, r);
      `CHK("strobe off keeps", 1'b1, d[IRQ_CONV])
      `CHK("cycle flag", 1'b1, d[IRQ_CYCLE])
      wstrb <= 4'hf;
      wr(OFS_IRQ_STAT, 32'h7, r);
      `CHK("clear resp", RESP_OKAY, r)
      rd(OFS_IRQ_STAT, d, r);
      `CHK("stat cleared", 32'h0, d)
      wr(OFS_IRQ_MASK, 32'h1, r);
      wait_done();
      #1;
      `CHK("irq on", 1'b1, irq)
      wr(OFS_IRQ_MASK, 32'h0, r);
      #1;
      `CHK("irq masked", 1'b0, irq)
      rd(OFS_IRQ_STAT, d, r);
      `CHK("stat sticky", 1'b1, d[IRQ_CONV])
      wr(OFS_IRQ_MASK, 32'h7, r);
      wait_done();
      wr(OFS_IRQ_STAT, 32'h7, r);
      #1;
      `CHK("irq cleared", 1'b0, irq)
      test_done();
   end
endmodule : tmw_input_word_tb_top
